// ==== core/ocs_cmd_core.sv ====
`timescale 1ns/1ps
// Purpose: Overlay command interpreter with setup and status registers
// Assumes: Serial front end delivers bytes as one-cycle strobes
// Notes:   Overlay pages live in two local arrays; display reads port b
// Operation
// - 30h returns to column one in roll mode; 31h clears row to end.
// - 32h selects roll page mode; 33h selects pop-on mode.
// - 36h swaps shown and hidden overlay memories.
// - 37h erases shown memory; 38h erases hidden memory.
// - A0h row code: low nibble row, bit 5 double height, column one.
// - A1h picks memory row from low nibble of argument.
// - A2h sets cursor column 00h to 20h; zero is preamble column.
// - A3h stores character at cursor, then advances cursor, holding at 20h.
// - A4h maps memory row to display row; bit4 show, bit5 double.
// - A5h stores character like A3h but marked double width.
// - A6h drops ready and holds commands for given frame count.
// - Codes C0h-FFh use graphics set under shadow, else extended.
// - Status bit 0 is sync lock; bit 1 high for first field.
// - Status flags output overrun, other interrupt, input overrun.
// - Status bit 6 data valid; bit 5 high when two bytes wait.
// - Config bit 0 picks TV standard; PAL forces 15-line rows.
// - Config bit 1 drives luminance on all three colours.
// - Config bits 2,3 pick lock sources; internal vertical gives irq pin.
// - Style bits 0-2: text shadow, row height, attribute disable.
// - Style bits 3-5: same choices for caption pages.
// - Style bits 6,7 overlay shadow and height, reset high.
// - Register write is C0h-DFh address byte then value byte.
// - First byte read is status, then output buffer data.
module ocs_cmd_core
#(
  parameter int ROWS = 16
)
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Command byte stream
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_byte,
  // Video side inputs (async)
  input  wire logic       i_frame_tick,
  input  wire logic       i_sync_lock,
  input  wire logic       i_field_one,
  // Events from the serial and output path
  input  wire logic       i_out_overrun,
  input  wire logic       i_in_overrun,
  input  wire logic       i_irq_pending,
  input  wire logic       i_out_valid,
  input  wire logic       i_out_two,
  input  wire logic       i_status_read,
  // Display memory read port
  input  wire logic [3:0] i_disp_row,
  input  wire logic [5:0] i_disp_col,
  output logic [8:0]      o_disp_glyph,
  output logic [3:0]      o_map_row,
  output logic [1:0]      o_map_attr,
  // Status and setup
  output logic [7:0]      o_status,
  output logic [7:0]      o_cfg,
  output logic [7:0]      o_style,
  output logic            o_pop_mode,
  output logic            o_page_sel,
  output logic            o_extended_set,
  output logic            o_rows_15,
  output logic            o_single_luma,
  output logic            o_irq_pin_mode
);
  import ocs_pkg::*;
  if (ROWS != 16)
  begin : g_rows_check
    $error("ROWS must be 16");
  end
  // Overlay memories: two pages, glyph plus wide flag
  logic [8:0] mem0 [ROWS*OCS_COLS];
  logic [8:0] mem1 [ROWS*OCS_COLS];
  ocs_state_t state_reg, state_next;
  logic [7:0] op_reg, op_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [7:0] style_reg, style_next;
  logic       pop_reg, pop_next;
  logic       page_reg, page_next;
  logic [3:0] mrow_reg, mrow_next;
  logic [5:0] col_reg, col_next;
  logic [7:0] wait_reg, wait_next;
  logic [3:0] map_row_reg [ROWS];
  logic [1:0] map_attr_reg [ROWS];
  logic       clr_page_reg, clr_page_next;
  logic [9:0] clr_idx_reg, clr_idx_next;
  logic [9:0] clr_end_reg, clr_end_next;
  logic [2:0] st_reg, st_next;
  logic [7:0] status_reg;
  logic       wr_en;
  logic       wr_page;
  logic [9:0] wr_idx;
  logic [8:0] wr_data;
  logic       map_we;
  logic       lock_s, field_s, frame_rise;
  logic       busy;
  logic [9:0] cur_idx;
  ocs_edge_sync u_lock (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_sync_lock),
                        .o_level(lock_s), .o_rise());
  ocs_edge_sync u_fld  (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_field_one),
                        .o_level(field_s), .o_rise());
  ocs_edge_sync u_frm  (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_frame_tick),
                        .o_level(), .o_rise(frame_rise));
  assign busy    = (wait_reg != 8'h00) | (state_reg == OCS_CLEAR);
  assign cur_idx = 10'(mrow_reg * OCS_COLS) + 10'(col_reg);
  always_comb
  begin
    state_next    = state_reg;
    op_next       = op_reg;
    cfg_next      = cfg_reg;
    style_next    = style_reg;
    pop_next      = pop_reg;
    page_next     = page_reg;
    mrow_next     = mrow_reg;
    col_next      = col_reg;
    wait_next     = wait_reg;
    clr_page_next = clr_page_reg;
    clr_idx_next  = clr_idx_reg;
    clr_end_next  = clr_end_reg;
    wr_en         = 1'b0;
    wr_page       = page_reg;
    wr_idx        = cur_idx;
    wr_data       = 9'h000;
    map_we        = 1'b0;
    if (wait_reg != 8'h00 && frame_rise)
      wait_next = wait_reg - 8'h01;
    case (state_reg)
      OCS_IDLE:
      begin
        if (i_cmd_valid && wait_reg == 8'h00)
        begin
          op_next = i_cmd_byte;
          case (i_cmd_byte)
            OCS_C_RETURN:
              if (!pop_reg)
                col_next = OCS_COL_ONE;
            OCS_C_CLEAR_TO_ROW_END_CMD:
            begin
              clr_page_next = pop_reg ? ~page_reg : page_reg;
              clr_idx_next  = cur_idx;
              clr_end_next  = 10'(mrow_reg * OCS_COLS) + 10'(OCS_COLS - 1);
              state_next    = OCS_CLEAR;
            end
            OCS_C_ROLL:  pop_next  = 1'b0;
            OCS_C_POPON: pop_next  = 1'b1;
            OCS_C_SWAP:  page_next = ~page_reg;
            OCS_C_ERSHOW, OCS_C_ERHIDE:
            begin
              clr_page_next = (i_cmd_byte == OCS_C_ERSHOW) ? page_reg : ~page_reg;
              clr_idx_next  = 10'h000;
              clr_end_next  = 10'(ROWS * OCS_COLS - 1);
              state_next    = OCS_CLEAR;
            end
            default:
            begin
              if (i_cmd_byte[7:4] == 4'ha && i_cmd_byte[3:0] <= 4'h6)
                state_next = OCS_ARG;
              else if (i_cmd_byte[7:5] == OCS_WR_HI)
                state_next = OCS_ARG;
              // Other codes fall through untouched
            end
          endcase
        end
      end
      OCS_ARG:
      begin
        if (i_cmd_valid)
        begin
          state_next = OCS_IDLE;
          if (op_reg[7:5] == OCS_WR_HI)
          begin
            if (op_reg[4:0] == OCS_CFG_ADDR)
              cfg_next = {4'h0, i_cmd_byte[3:0] & OCS_CFG_MASK};
            else if (op_reg[4:0] == OCS_STYLE_ADDR)
              style_next = i_cmd_byte;
          end
          else
          begin
            case (op_reg)
              OCS_C_ROWSEL:
              begin
                mrow_next = i_cmd_byte[3:0];
                col_next  = OCS_COL_ONE;
                map_we    = 1'b1;
              end
              OCS_C_MEMROW: mrow_next = i_cmd_byte[3:0];
              OCS_C_CURSOR:
                if (i_cmd_byte <= {2'b00, OCS_COL_MAX})
                  col_next = i_cmd_byte[5:0];
              OCS_C_WRCHR, OCS_C_WIDE:
              begin
                wr_en   = 1'b1;
                wr_page = pop_reg ? ~page_reg : page_reg;
                wr_data = {op_reg == OCS_C_WIDE, i_cmd_byte};
                if (col_reg < OCS_COL_MAX)
                  col_next = col_reg + 6'h01;
              end
              OCS_C_MAP:  map_we    = 1'b1;
              OCS_C_WAIT: wait_next = i_cmd_byte;
              default:    state_next = OCS_IDLE;
            endcase
          end
        end
      end
      OCS_CLEAR:
      begin
        wr_en   = 1'b1;
        wr_page = clr_page_reg;
        wr_idx  = clr_idx_reg;
        wr_data = {1'b0, OCS_BLANK};
        clr_idx_next = clr_idx_reg + 10'h001;
        if (clr_idx_reg == clr_end_reg)
          state_next = OCS_IDLE;
      end
      default: state_next = OCS_IDLE;
    endcase
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_reg    <= OCS_IDLE;
      op_reg       <= 8'h00;
      cfg_reg      <= OCS_CFG_RST;
      style_reg    <= OCS_STYLE_RST;
      pop_reg      <= 1'b0;
      page_reg     <= 1'b0;
      mrow_reg     <= 4'h0;
      col_reg      <= 6'h00;
      wait_reg     <= 8'h00;
      clr_page_reg <= 1'b0;
      clr_idx_reg  <= 10'h000;
      clr_end_reg  <= 10'h000;
    end
    else
    begin
      state_reg    <= state_next;
      op_reg       <= op_next;
      cfg_reg      <= cfg_next;
      style_reg    <= style_next;
      pop_reg      <= pop_next;
      page_reg     <= page_next;
      mrow_reg     <= mrow_next;
      col_reg      <= col_next;
      wait_reg     <= wait_next;
      clr_page_reg <= clr_page_next;
      clr_idx_reg  <= clr_idx_next;
      clr_end_reg  <= clr_end_next;
    end
  end
  // Memory and row map writes
  always_ff @(posedge i_clk)
  begin
    if (wr_en && !wr_page)
      mem0[wr_idx] <= wr_data;
    if (wr_en && wr_page)
      mem1[wr_idx] <= wr_data;
    if (map_we)
    begin
      map_row_reg[mrow_reg]  <= i_cmd_byte[3:0];
      map_attr_reg[mrow_reg] <= (op_reg == OCS_C_MAP) ?
        {i_cmd_byte[OCS_DBL_BIT], i_cmd_byte[OCS_SHOW_BIT]} :
        {i_cmd_byte[OCS_DBL_BIT], 1'b1};
    end
    o_disp_glyph <= page_reg ? mem1[10'(i_disp_row * OCS_COLS) + 10'(i_disp_col)]
                             : mem0[10'(i_disp_row * OCS_COLS) + 10'(i_disp_col)];
    o_map_row  <= map_row_reg[i_disp_row];
    o_map_attr <= map_attr_reg[i_disp_row];
  end
  // Status flags: sticky error bits, set wins over read clear
  always_comb
  begin
    st_next = st_reg;
    if (i_status_read)
      st_next = 3'h0;
    if (i_out_overrun)
      st_next[0] = 1'b1;
    if (i_in_overrun)
      st_next[1] = 1'b1;
    st_next[2] = i_irq_pending;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_reg     <= 3'h0;
      status_reg <= OCS_STATUS_RST;
    end
    else
    begin
      st_reg <= st_next;
      status_reg[OCS_ST_LOCK] <= lock_s;
      status_reg[OCS_ST_FLD]  <= field_s;
      status_reg[OCS_ST_OUTPUT_OVERRUN_FLAG] <= st_next[0];
      status_reg[OCS_ST_IRQ_PENDING_FLAG] <= st_next[2];
      status_reg[OCS_ST_INPUT_OVERRUN_FLAG] <= st_next[1];
      status_reg[OCS_ST_RD2]  <= i_out_valid & i_out_two;
      status_reg[OCS_ST_DAV]  <= i_out_valid;
      status_reg[OCS_ST_RDY]  <= ~busy & ~(i_cmd_valid & (wait_next != 8'h00));
    end
  end
  assign o_status       = status_reg;
  assign o_cfg          = cfg_reg;
  assign o_style        = style_reg;
  assign o_pop_mode     = pop_reg;
  assign o_page_sel     = page_reg;
  assign o_extended_set = ~style_reg[OCS_OVERLAY_SHADOW_SEL_BIT];
  assign o_rows_15      = style_reg[OCS_O15_BIT] | cfg_reg[OCS_TVS_BIT];
  assign o_single_luma  = cfg_reg[OCS_SINGLE_LUMA_SEL_BIT];
  assign o_irq_pin_mode = ~cfg_reg[OCS_VLK_BIT];
  a_cfg_reserved: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_reg[7:4] == 4'h0) else $error("config reserved bits set");
  a_wait_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (wait_reg != 8'h00) |-> ##1 !status_reg[OCS_ST_RDY])
    else $error("ready high while waiting");
  a_dav_copy: assert property (@(posedge i_clk) disable iff (i_rst)
    i_out_valid |=> status_reg[OCS_ST_DAV]) else $error("data valid lost");
  a_overrun_set: assert property (@(posedge i_clk) disable iff (i_rst)
    i_out_overrun |=> status_reg[OCS_ST_OUTPUT_OVERRUN_FLAG]) else $error("overrun lost");
  a_swap_page: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg == OCS_IDLE && i_cmd_valid && wait_reg == 8'h00 &&
     i_cmd_byte == OCS_C_SWAP) |=> (page_reg != $past(page_reg)))
    else $error("page swap missed");
  a_popon_set: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg == OCS_IDLE && i_cmd_valid && wait_reg == 8'h00 &&
     i_cmd_byte == OCS_C_POPON) |=> pop_reg) else $error("pop-on missed");
  a_rowsel_col: assert property (@(posedge i_clk) disable iff (i_rst)
    (state_reg == OCS_ARG && i_cmd_valid && op_reg == OCS_C_ROWSEL)
    |=> col_reg == OCS_COL_ONE) else $error("row select column");
  a_col_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    col_reg <= OCS_COL_MAX) else $error("cursor past last column");
endmodule

// ==== core/ocs_pkg.sv ====
// Purpose: Shared constants for the overlay command interpreter
// Assumes: Byte-wide command stream from the serial port front end
// Notes:   Offsets, field positions, reset values and command codes
package ocs_pkg;
  // Register offsets (five-bit write address)
  localparam logic [4:0] OCS_CFG_ADDR   = 5'h00;
  localparam logic [4:0] OCS_STYLE_ADDR = 5'h01;
  // Reset values
  localparam logic [7:0] OCS_CFG_RST    = 8'h00;
  localparam logic [7:0] OCS_STYLE_RST  = 8'hc0;
  localparam logic [7:0] OCS_STATUS_RST = 8'h80;
  localparam logic [3:0] OCS_CFG_MASK   = 4'hf;
  // Config field positions
  localparam int OCS_TVS_BIT  = 0;
  localparam int OCS_SINGLE_LUMA_SEL_BIT = 1;
  localparam int OCS_HLK_BIT  = 2;
  localparam int OCS_VLK_BIT  = 3;
  // Style field positions
  localparam int OCS_TEXT_SHADOW_SEL_BIT = 0;
  localparam int OCS_T15_BIT  = 1;
  localparam int OCS_TEXT_ATTR_DISABLE_BIT = 2;
  localparam int OCS_CAPTION_SHADOW_SEL_BIT = 3;
  localparam int OCS_C15_BIT  = 4;
  localparam int OCS_CAPTION_ATTR_DISABLE_BIT = 5;
  localparam int OCS_OVERLAY_SHADOW_SEL_BIT = 6;
  localparam int OCS_O15_BIT  = 7;
  // Status byte field positions
  localparam int OCS_ST_LOCK = 0;
  localparam int OCS_ST_FLD  = 1;
  localparam int OCS_ST_OUTPUT_OVERRUN_FLAG = 2;
  localparam int OCS_ST_IRQ_PENDING_FLAG = 3;
  localparam int OCS_ST_INPUT_OVERRUN_FLAG = 4;
  localparam int OCS_ST_RD2  = 5;
  localparam int OCS_ST_DAV  = 6;
  localparam int OCS_ST_RDY  = 7;
  // Single-byte overlay commands
  localparam logic [7:0] OCS_C_RETURN = 8'h30;
  localparam logic [7:0] OCS_C_CLEAR_TO_ROW_END_CMD   = 8'h31;
  localparam logic [7:0] OCS_C_ROLL   = 8'h32;
  localparam logic [7:0] OCS_C_POPON  = 8'h33;
  localparam logic [7:0] OCS_C_SWAP   = 8'h36;
  localparam logic [7:0] OCS_C_ERSHOW = 8'h37;
  localparam logic [7:0] OCS_C_ERHIDE = 8'h38;
  // Two-byte overlay commands
  localparam logic [7:0] OCS_C_ROWSEL = 8'ha0;
  localparam logic [7:0] OCS_C_MEMROW = 8'ha1;
  localparam logic [7:0] OCS_C_CURSOR = 8'ha2;
  localparam logic [7:0] OCS_C_WRCHR  = 8'ha3;
  localparam logic [7:0] OCS_C_MAP    = 8'ha4;
  localparam logic [7:0] OCS_C_WIDE   = 8'ha5;
  localparam logic [7:0] OCS_C_WAIT   = 8'ha6;
  localparam logic [2:0] OCS_WR_HI    = 3'b110;
  // Layout
  localparam int         OCS_COLS     = 34;
  localparam logic [5:0] OCS_COL_MAX  = 6'h20;
  localparam logic [5:0] OCS_COL_ONE  = 6'h01;
  localparam logic [7:0] OCS_GLYPH_LO = 8'hc0;
  localparam logic [7:0] OCS_BLANK    = 8'h20;
  // Bit 5 double height, bit 4 show row
  localparam int OCS_DBL_BIT  = 5;
  localparam int OCS_SHOW_BIT = 4;
  typedef enum logic [2:0] {
    OCS_IDLE  = 3'b001,
    OCS_ARG   = 3'b010,
    OCS_CLEAR = 3'b100
  } ocs_state_t;
endpackage

// ==== core/ocs_edge_sync.sv ====
`timescale 1ns/1ps
// Purpose: Two-flop synchroniser with rising edge pulse
// Assumes: Input from another clock domain
// Notes:   Edge taken between second and third flop only
module ocs_edge_sync
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Async level in
  input  wire logic i_async,
  // Synchronised level and rising edge
  output logic      o_level,
  output logic      o_rise
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;

  always_comb
  begin
    sh_next = {sh_reg[1:0], i_async};
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      sh_reg <= 3'h0;
    else
      sh_reg <= sh_next;
  end

  assign o_level = sh_reg[1];
  assign o_rise  = sh_reg[1] & ~sh_reg[2];
endmodule

// ==== verif/ocs_host_model.sv ====
`timescale 1ns/1ps
// Purpose: Host model feeding command bytes to the interpreter
// Assumes: Ready is status bit 7 and falls at most one cycle after a taken byte
// Notes:   A byte leaves 1 ns after a rising edge and stands one cycle
module ocs_host_model
(
  // Clock and status
  input  wire logic       i_clk,
  input  wire logic [7:0] i_status,
  // Command stream
  output logic            o_cmd_valid,
  output logic [7:0]      o_cmd_byte
);
  import ocs_pkg::*;
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_byte  = 8'h00;
  end
  // Holds off while ready is low, since a byte sent then is lost
  task automatic send(input logic [7:0] b, output bit ok);
    int n;
    n  = 0;
    ok = 1'b0;
    while (i_status[OCS_ST_RDY] !== 1'b1 && n < 3000)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n < 3000)
    begin
      ok = 1'b1;
      @(posedge i_clk);
      #1;
      o_cmd_valid = 1'b1;
      o_cmd_byte  = b;
      @(posedge i_clk);
      #1;
      o_cmd_valid = 1'b0;
      // Released data shows the inverse so stale bytes never match
      o_cmd_byte  = ~b;
      repeat (2) @(posedge i_clk);
      // Step off the edge so status is read once it has settled
      #1;
    end
  endtask
endmodule

// ==== verif/tb_osd_command_and_setup_regs.sv ====
`timescale 1ns/1ps
// Purpose: Self-checking bench for the overlay command interpreter
// Assumes: Host model paces every byte on the ready bit
// Notes:   Frame tick runs free with an 800 ns period
module tb_osd_command_and_setup_regs;
  import ocs_pkg::*;
  logic       clk  = 1'b0;
  logic       rst  = 1'b1;
  logic       tick = 1'b0;
  logic       valid;
  logic [7:0] cbyte;
  logic [7:0] ev;
  logic [3:0] row;
  logic [5:0] col;
  logic [8:0] glyph;
  logic [3:0] mrow;
  logic [1:0] mattr;
  logic [7:0] status;
  logic [7:0] cfg;
  logic [7:0] style;
  logic       pop;
  logic       page;
  logic       ext;
  logic       r15;
  logic       luma;
  logic       irqm;
  int         fails   = 0;
  int         checked = 0;
  int         n;

  always #50 clk = ~clk;
  always #400 tick = ~tick;

  ocs_host_model host (.i_clk(clk), .i_status(status), .o_cmd_valid(valid), .o_cmd_byte(cbyte));

  ocs_cmd_core #(.ROWS(16)) uut
  (
    .i_clk(clk), .i_rst(rst), .i_cmd_valid(valid), .i_cmd_byte(cbyte),
    .i_frame_tick(tick), .i_sync_lock(ev[0]), .i_field_one(ev[1]),
    .i_out_overrun(ev[2]), .i_in_overrun(ev[4]), .i_irq_pending(ev[3]),
    .i_out_valid(ev[6]), .i_out_two(ev[5]), .i_status_read(ev[7]),
    .i_disp_row(row), .i_disp_col(col), .o_disp_glyph(glyph),
    .o_map_row(mrow), .o_map_attr(mattr), .o_status(status), .o_cfg(cfg),
    .o_style(style), .o_pop_mode(pop), .o_page_sel(page), .o_extended_set(ext),
    .o_rows_15(r15), .o_single_luma(luma), .o_irq_pin_mode(irqm)
  );

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] b);
    bit ok;
    host.send(b, ok);
    if (!ok)
    begin
      fails++;
      report_and_stop();
    end
  endtask

  task automatic cmd2(input logic [7:0] op, input logic [7:0] arg);
    cmd(op);
    cmd(arg);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    cmd2({OCS_WR_HI, a}, v);
  endtask

  // Reads the shown page; glyph output lags the address by one cycle
  task automatic look(input logic [3:0] r, input logic [5:0] c, input logic [8:0] exp);
    cyc(1);
    row = r;
    col = c;
    cyc(2);
    check("glyph", glyph, exp);
  endtask

  initial
  begin
    ev  = 8'h00;
    row = 4'h0;
    col = 6'h00;
    cyc(6);
    rst = 1'b0;
    cyc(4);
    check("status", 9'(status), 9'h080);
    check("cfg", 9'(cfg), 9'h000);
    check("style", 9'(style), 9'h0c0);
    check("modes", {5'h00, pop, page, luma, irqm}, 9'h001);
    check("sets", {7'h00, ext, r15}, 9'h001);
    // Lock, first field, other irq, two bytes waiting, data valid
    ev = 8'h6b;
    cyc(5);
    check("status", 9'(status), 9'h0eb);
    ev = 8'h7f;
    cyc(1);
    ev = 8'h6b;
    cyc(4);
    check("status", 9'(status), 9'h0ff);
    ev = 8'heb;
    cyc(1);
    ev = 8'h6b;
    cyc(4);
    check("status", 9'(status), 9'h0eb);
    ev = 8'h00;
    cyc(5);
    check("status", 9'(status), 9'h080);
    wr(OCS_CFG_ADDR, 8'hff);
    wr(OCS_STYLE_ADDR, 8'h3f);
    wr(5'h05, 8'h55);
    check("cfg", 9'(cfg), 9'h00f);
    check("style", 9'(style), 9'h03f);
    check("modes", {5'h00, pop, page, luma, irqm}, 9'h002);
    check("sets", {7'h00, ext, r15}, 9'h003);
    wr(OCS_CFG_ADDR, 8'h00);
    check("sets", {7'h00, ext, r15}, 9'h002);
    check("modes", {5'h00, pop, page, luma, irqm}, 9'h001);
    wr(OCS_STYLE_ADDR, 8'hc0);
    check("style", 9'(style), 9'h0c0);
    cmd(OCS_C_POPON);
    check("pop", 9'(pop), 9'h001);
    cmd(OCS_C_ROLL);
    check("pop", 9'(pop), 9'h000);
    cmd(OCS_C_ERSHOW);
    cmd(8'h34);
    cmd2(OCS_C_MEMROW, 8'h03);
    cmd2(OCS_C_MAP, 8'h13);
    cmd2(OCS_C_CURSOR, 8'h05);
    cmd2(OCS_C_WRCHR, 8'h41);
    cmd2(OCS_C_WIDE, 8'h42);
    cmd2(OCS_C_CURSOR, 8'h21);
    cmd2(OCS_C_WRCHR, 8'h43);
    look(4'h3, 6'h05, 9'h041);
    look(4'h3, 6'h06, 9'h142);
    look(4'h3, 6'h07, 9'h043);
    look(4'h3, 6'h08, 9'h020);
    check("map", {3'h0, mrow, mattr}, 9'h00d);
    cmd2(OCS_C_CURSOR, 8'h06);
    cmd(OCS_C_CLEAR_TO_ROW_END_CMD);
    cmd(8'h34);
    look(4'h3, 6'h06, 9'h020);
    look(4'h3, 6'h05, 9'h041);
    cmd(OCS_C_RETURN);
    cmd2(OCS_C_WRCHR, 8'h44);
    cmd(8'h35);
    cmd2(OCS_C_WRCHR, 8'h45);
    look(4'h3, 6'h01, 9'h044);
    look(4'h3, 6'h02, 9'h045);
    cmd2(OCS_C_ROWSEL, 8'h23);
    cmd2(OCS_C_WRCHR, 8'h46);
    look(4'h3, 6'h01, 9'h046);
    check("map", {3'h0, mrow, mattr}, 9'h00f);
    cmd(OCS_C_POPON);
    cmd(OCS_C_ERHIDE);
    cmd(8'h34);
    cmd2(OCS_C_CURSOR, 8'h02);
    cmd2(OCS_C_WRCHR, 8'h47);
    look(4'h3, 6'h02, 9'h045);
    cmd(OCS_C_SWAP);
    check("page", 9'(page), 9'h001);
    look(4'h3, 6'h02, 9'h047);
    look(4'h3, 6'h05, 9'h020);
    cmd2(OCS_C_WAIT, 8'h02);
    check("ready", 9'(status[OCS_ST_RDY]), 9'h000);
    n = 0;
    while (status[OCS_ST_RDY] !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
    check("wait", 9'(n >= 8 && n < 60), 9'h001);
    report_and_stop();
  end
endmodule
